/* pkg/sarseq_pkg.sv */
// Types and constants of the skip and table reference sequencer
package sarseq_pkg;

  // ==========================================
  // Addresses and field layouts
  localparam logic [11:0] TBL_BASE  = 12'h020;
  localparam logic [11:0] TBL_TOP   = 12'h07f;
  localparam logic [4:0]  TBL_PAD   = 5'h00;
  localparam logic        TBL_EVEN  = 1'b0;
  localparam logic [11:0] MEMA_LO   = 12'hfb0;
  localparam logic [11:0] MEMA_HI   = 12'hff0;
  localparam logic [11:0] MEMB_LO   = 12'hfc0;
  localparam logic [7:0]  ABS_PAD   = 8'h00;
  localparam logic [7:0]  MEMB_PAD  = 8'h00;
  localparam logic [3:0]  BANK_ROOT = 4'h0;
  localparam logic [3:0]  BANK_IO   = 4'hf;
  localparam int          PTR_TOP   = 3;

  // ==========================================
  // Lengths and skip costs
  localparam logic [1:0] LEN_NONE   = 2'h0;
  localparam logic [1:0] LEN_ONE    = 2'h1;
  localparam logic [1:0] LEN_THREE  = 2'h3;
  localparam logic [1:0] COST_SHORT = 2'h1;
  localparam logic [1:0] COST_LONG  = 2'h2;

  // ==========================================
  // Enumerations
  typedef enum logic [4:0] {
    OP_OTHER, OP_REF, OP_LD_A_IMM, OP_LD_XACC_IMM, OP_LD_PTR_IMM,
    OP_LD_A_IND, OP_ST_A_IND, OP_INCREMENT_SKIP_OP_R, OP_INCREMENT_SKIP_OP_RR, OP_DECREMENT_SKIP_OP_R,
    OP_STEP_SKIP, OP_TEST_SKIP, OP_CARRY, OP_ADD_CARRY_IND,
    OP_SUB_BORROW_IND, OP_ADD_AND_SKIP, OP_EXCHANGE_DIRECT,
    OP_TABLE_JUMP_PSEUDO, OP_TABLE_CALL_PSEUDO, OP_BIT
  } sarseq_op_t;

  typedef enum logic [1:0] {RED_NONE, RED_ACC, RED_PTR} sarseq_red_t;
  typedef enum logic [1:0] {BM_ABS, BM_PTR_LOW, BM_PTR_HIGH} sarseq_bm_t;
  typedef enum logic [1:0] {SQ_RUN, SQ_ITEM1, SQ_ITEM2} sarseq_fsm_t;

  // ==========================================
  // Carriers
  typedef struct packed {
    sarseq_op_t  op;
    logic [1:0]  len;
    logic        msb;
    logic [5:0]  tidx;
    logic [12:0] tgt;
    sarseq_bm_t  bmode;
    logic        bhigh;
    logic [3:0]  da;
    logic [1:0]  bitn;
  } sarseq_ins_t;

  typedef struct packed {logic ovf; logic brw; logic cond;} sarseq_res_t;

  typedef struct packed {
    logic [3:0] l;
    logic [3:0] h;
    logic       bank_en;
    logic [3:0] bank_sel;
  } sarseq_ctx_t;

  typedef struct packed {
    logic        valid;
    logic        exec;
    logic        nop;
    logic        tbl;
    logic        err;
    logic        carry_we;
    logic        jump;
    logic        call;
    logic [12:0] tgt;
    logic [1:0]  pc_inc;
    logic [1:0]  extra;
  } sarseq_ctl_t;

  typedef struct packed {logic valid; logic [11:0] addr;} sarseq_treq_t;

  typedef struct packed {
    logic        valid;
    logic [11:0] addr;
    logic [1:0]  bitn;
  } sarseq_bita_t;

  typedef struct packed {
    sarseq_fsm_t  fsm;
    logic         skip;
    sarseq_red_t  red;
    logic         pair;
    logic         pair_skip;
    sarseq_ctl_t  ctl;
    sarseq_treq_t treq;
    sarseq_bita_t bita;
  } sarseq_state_t;

  function automatic sarseq_red_t red_group(sarseq_op_t op);
    if (op == OP_LD_A_IMM || op == OP_LD_XACC_IMM) return RED_ACC;
    else if (op == OP_LD_PTR_IMM) return RED_PTR;
    else return RED_NONE;
  endfunction : red_group

endpackage : sarseq_pkg

/* rtl/sarseq_bitaddr.sv */
// Bit address former for the three bit addressing modes
`timescale 1ns/10ps
`default_nettype none

module sarseq_bitaddr (
  input  wire sarseq_pkg::sarseq_ins_t  ins_i,
  input  wire sarseq_pkg::sarseq_ctx_t  ctx_i,
  output var  sarseq_pkg::sarseq_bita_t bita_o
);
  import sarseq_pkg::*;

  logic [3:0] bank;

  always_comb begin
    // Bank restricted to root or I/O bank unless enabled
    bank = ctx_i.bank_en ? ctx_i.bank_sel
         : (ctx_i.h[PTR_TOP] ? BANK_IO : BANK_ROOT);
    bita_o.valid = 1'b1;
    bita_o.bitn  = ins_i.bitn;
    case (ins_i.bmode)
      BM_ABS: begin
        bita_o.addr = (ins_i.bhigh ? MEMA_HI : MEMA_LO)
                    | {ABS_PAD, ins_i.da};
      end
      BM_PTR_LOW: begin
        bita_o.addr = MEMB_LO | {MEMB_PAD, ins_i.da[3:2], ctx_i.l[3:2]};
        bita_o.bitn = ctx_i.l[1:0];
      end
      default: begin
        bita_o.addr = {bank, ctx_i.h, ins_i.da};
      end
    endcase
  end

endmodule : sarseq_bitaddr
`default_nettype wire

/* rtl/sarseq_core.sv */
// Skip, redundancy and table reference sequencer of the 4-bit core
`timescale 1ns/10ps
`default_nettype none

module sarseq_core (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     ce_i,
  input  wire logic                     ins_valid_i,
  input  wire sarseq_pkg::sarseq_ins_t  ins_i,
  input  wire sarseq_pkg::sarseq_res_t  res_i,
  input  wire sarseq_pkg::sarseq_ctx_t  ctx_i,
  output var  sarseq_pkg::sarseq_ctl_t  ctl_o,
  output var  sarseq_pkg::sarseq_treq_t treq_o,
  output var  sarseq_pkg::sarseq_bita_t bita_o,
  output logic                          skip_o
);
  import sarseq_pkg::*;

  // ==========================================
  // State
  sarseq_state_t st;
  sarseq_state_t next_st;
  sarseq_bita_t  bit_calc;
  sarseq_red_t   grp;
  logic [11:0]   tbl_addr;
  logic          bad;
  logic          first_ok;
  logic          second_ok;

  sarseq_bitaddr u_bitaddr (
    .ins_i  (ins_i),
    .ctx_i  (ctx_i),
    .bita_o (bit_calc)
  );

  assign ctl_o  = st.ctl;
  assign treq_o = st.treq;
  assign bita_o = st.bita;
  assign skip_o = st.skip;

  // ==========================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.ctl = '0;
    next_st.treq.valid = 1'b0;
    next_st.bita.valid = 1'b0;
    grp = red_group(ins_i.op);
    tbl_addr = {TBL_PAD, ins_i.tidx, TBL_EVEN};
    first_ok = ins_i.op == OP_LD_A_IMM || ins_i.op == OP_LD_A_IND
             || ins_i.op == OP_ST_A_IND;
    second_ok = ins_i.op == OP_INCREMENT_SKIP_OP_R || ins_i.op == OP_INCREMENT_SKIP_OP_RR
              || ins_i.op == OP_DECREMENT_SKIP_OP_R;
    bad = 1'b0;
    if (st.fsm == SQ_ITEM1) begin
      bad = ins_i.op == OP_EXCHANGE_DIRECT
          || ins_i.op == OP_REF
          || (ins_i.len == LEN_ONE
              && (!ins_i.msb || !first_ok));
    end else if (st.fsm == SQ_ITEM2) begin
      bad = !second_ok;
    end else begin
      bad = ins_i.op == OP_TABLE_JUMP_PSEUDO
          || ins_i.op == OP_TABLE_CALL_PSEUDO
          || (ins_i.op == OP_REF
              && (tbl_addr < TBL_BASE || tbl_addr > TBL_TOP));
    end
    if (ins_valid_i) begin
      next_st.ctl.valid = 1'b1;
      next_st.ctl.tbl = st.fsm != SQ_RUN;
      // Program counter frozen inside the table
      next_st.ctl.pc_inc = (st.fsm == SQ_RUN) ? ins_i.len
                         : LEN_NONE;
      next_st.pair = 1'b0;
      next_st.pair_skip = 1'b0;
      if (st.skip && st.fsm == SQ_RUN) begin
        next_st.skip = 1'b0;
        next_st.ctl.nop = 1'b1;
        if (ins_i.op == OP_REF) begin
          next_st.ctl.pc_inc = LEN_ONE;
          next_st.ctl.extra = COST_SHORT;
        end else begin
          next_st.ctl.extra = (ins_i.len == LEN_THREE) ? COST_LONG
                            : COST_SHORT;
        end
      end else if (grp != RED_NONE && grp == st.red && !bad) begin
        // Red group kept so a whole string collapses
        next_st.ctl.nop = 1'b1;
      end else if (st.pair && st.pair_skip && st.fsm == SQ_RUN
                   && ins_i.op == OP_ADD_AND_SKIP) begin
        next_st.ctl.nop = 1'b1;
        next_st.ctl.extra = COST_SHORT;
        next_st.red = RED_NONE;
      end else if (bad) begin
        next_st.ctl.nop = 1'b1;
        next_st.ctl.err = 1'b1;
        next_st.red = RED_NONE;
        if (st.fsm != SQ_RUN) begin
          next_st.fsm = SQ_RUN;
          next_st.ctl.pc_inc = LEN_ONE;
        end
      end else begin
        next_st.ctl.exec = 1'b1;
        // A reference clears the group, so its item is never dropped
        next_st.red = grp;
        case (ins_i.op)
          OP_REF: begin
            next_st.treq.valid = 1'b1;
            next_st.treq.addr = tbl_addr;
            next_st.fsm = SQ_ITEM1;
            next_st.ctl.pc_inc = LEN_NONE;
          end
          OP_ADD_CARRY_IND: begin
            next_st.ctl.carry_we = 1'b1;
            next_st.pair = 1'b1;
            next_st.pair_skip = res_i.ovf;
          end
          OP_SUB_BORROW_IND: begin
            next_st.ctl.carry_we = 1'b1;
            next_st.pair = 1'b1;
            next_st.pair_skip = !res_i.brw;
          end
          OP_ADD_AND_SKIP: begin
            next_st.skip = st.pair ? 1'b0 : res_i.ovf;
          end
          OP_INCREMENT_SKIP_OP_R, OP_INCREMENT_SKIP_OP_RR, OP_DECREMENT_SKIP_OP_R, OP_STEP_SKIP: begin
            next_st.skip = res_i.ovf | res_i.brw;
          end
          OP_TEST_SKIP: begin
            next_st.skip = res_i.cond;
          end
          OP_CARRY: begin
            next_st.ctl.carry_we = 1'b1;
          end
          OP_TABLE_JUMP_PSEUDO: begin
            next_st.ctl.jump = 1'b1;
            next_st.ctl.tgt = ins_i.tgt;
          end
          OP_TABLE_CALL_PSEUDO: begin
            next_st.ctl.call = 1'b1;
            next_st.ctl.tgt = ins_i.tgt;
          end
          OP_BIT: begin
            next_st.bita = bit_calc;
          end
          default: begin
          end
        endcase
        if (st.fsm == SQ_ITEM1 && ins_i.len == LEN_ONE) begin
          next_st.fsm = SQ_ITEM2;
        end else if (st.fsm != SQ_RUN) begin
          next_st.fsm = SQ_RUN;
          // Resume after the opcode unless the entry branched
          if (!next_st.ctl.jump && !next_st.ctl.call) begin
            next_st.ctl.pc_inc = LEN_ONE;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_run;
    ce_i && ins_valid_i && !st.skip && st.fsm == SQ_RUN;
  endsequence

  sequence s_ref_taken;
    s_run ##0 ins_i.op == OP_REF;
  endsequence

  sequence s_item1;
    ce_i && ins_valid_i && st.fsm == SQ_ITEM1;
  endsequence

  property p_ref_fetch;
    s_ref_taken |=> ctl_o.err || (treq_o.valid
      && treq_o.addr >= TBL_BASE && treq_o.addr <= TBL_TOP
      && ctl_o.pc_inc == LEN_NONE && st.red == RED_NONE);
  endproperty
  a_ref_fetch : assert property (p_ref_fetch)
    else $error("reference fetch wrong");

  property p_ref_skipped;
    ce_i && ins_valid_i && st.skip && st.fsm == SQ_RUN
      && ins_i.op == OP_REF
      |=> ctl_o.nop && ctl_o.extra == COST_SHORT && !treq_o.valid
      && !skip_o && st.fsm == SQ_RUN;
  endproperty
  a_ref_skipped : assert property (p_ref_skipped)
    else $error("skipped reference misbehaved");

  property p_skip_cost;
    ce_i && ins_valid_i && st.skip && st.fsm == SQ_RUN
      && ins_i.op != OP_REF && ins_i.len == LEN_THREE
      |=> ctl_o.extra == COST_LONG && ctl_o.pc_inc == LEN_THREE;
  endproperty
  a_skip_cost : assert property (p_skip_cost)
    else $error("long skip cost wrong");

  property p_redundant;
    s_run ##0 (red_group(ins_i.op) != RED_NONE
      && red_group(ins_i.op) == st.red)
      |=> ctl_o.nop && !ctl_o.exec && $stable(st.red);
  endproperty
  a_redundant : assert property (p_redundant)
    else $error("redundant load executed");

  property p_step_skip;
    s_run ##0 !st.pair && ins_i.op == OP_STEP_SKIP
      |=> skip_o == $past(res_i.ovf | res_i.brw) && !ctl_o.carry_we;
  endproperty
  a_step_skip : assert property (p_step_skip)
    else $error("step skip wrong");

  property p_test_skip;
    s_run ##0 ins_i.op == OP_TEST_SKIP
      |=> skip_o == $past(res_i.cond) && !ctl_o.carry_we;
  endproperty
  a_test_skip : assert property (p_test_skip)
    else $error("test skip wrong");

  property p_carry_only;
    s_run ##0 ins_i.op == OP_CARRY |=> ctl_o.carry_we && !skip_o;
  endproperty
  a_carry_only : assert property (p_carry_only)
    else $error("carry instruction skipped");

  property p_pair_no_skip;
    s_run ##0 st.pair && !st.pair_skip && ins_i.op == OP_ADD_AND_SKIP
      |=> ctl_o.exec && !skip_o;
  endproperty
  a_pair_no_skip : assert property (p_pair_no_skip)
    else $error("paired add-skip skipped");

  // Idle cycle between the pair; nothing taken may break it
  sequence s_gap;
    !(ce_i && ins_valid_i);
  endsequence

  property p_pair_skip;
    s_run ##0 ins_i.op == OP_ADD_CARRY_IND && res_i.ovf
      ##1 s_gap ##1 (s_run ##0 ins_i.op == OP_ADD_AND_SKIP)
      |=> ctl_o.nop && !skip_o && ctl_o.extra == COST_SHORT;
  endproperty
  a_pair_skip : assert property (p_pair_skip)
    else $error("add-skip not bypassed");

  property p_exch_refused;
    s_item1 ##0 ins_i.op == OP_EXCHANGE_DIRECT
      |=> ctl_o.err && !ctl_o.exec && st.fsm == SQ_RUN;
  endproperty
  a_exch_refused : assert property (p_exch_refused)
    else $error("exchange accepted in table");

  property p_msb_refused;
    s_item1 ##0 ins_i.len == LEN_ONE && !ins_i.msb |=> ctl_o.err;
  endproperty
  a_msb_refused : assert property (p_msb_refused)
    else $error("msb zero item accepted");

  property p_pseudo_jump;
    s_item1 ##0 ins_i.op == OP_TABLE_JUMP_PSEUDO
      |=> ctl_o.jump && ctl_o.tgt == $past(ins_i.tgt)
      && st.fsm == SQ_RUN && ctl_o.pc_inc == LEN_NONE;
  endproperty
  a_pseudo_jump : assert property (p_pseudo_jump)
    else $error("pseudo jump lost");

endmodule : sarseq_core
`default_nettype wire

/* tb/sarseq_mem_model.sv */
// Program memory model answering table entry fetches
`timescale 1ns/10ps
`default_nettype none

module sarseq_mem_model (
  input  wire logic                     ref_clk_i,
  input  wire sarseq_pkg::sarseq_treq_t treq_i,
  output var  sarseq_pkg::sarseq_ins_t  item_a_o,
  output var  sarseq_pkg::sarseq_ins_t  item_b_o,
  output var  logic                     two_o
);
  import sarseq_pkg::*;

  function automatic sarseq_ins_t mk(sarseq_op_t op, logic [1:0] len,
                                     logic msb, logic [12:0] tgt);
    mk = '0;
    mk.op = op;
    mk.len = len;
    mk.msb = msb;
    mk.tgt = tgt;
  endfunction : mk

  // ==========================================
  // Entry table, even starts only
  // Answers one edge after the request, then holds until the next one
  always @(posedge ref_clk_i) begin
    if (treq_i.valid) begin
      two_o <= 1'b0;
      item_b_o <= mk(OP_OTHER, 2'h1, 1'b1, 13'h0000);
      case (treq_i.addr)
        12'h020: begin
          item_a_o <= mk(OP_LD_A_IMM, 2'h1, 1'b1, 13'h0000);
          item_b_o <= mk(OP_INCREMENT_SKIP_OP_R, 2'h1, 1'b1, 13'h0000);
          two_o <= 1'b1;
        end
        12'h024: begin
          item_a_o <= mk(OP_EXCHANGE_DIRECT, 2'h2, 1'b1, 13'h0000);
        end
        12'h026: begin
          item_a_o <= mk(OP_TABLE_JUMP_PSEUDO, 2'h2, 1'b1, 13'h1234);
        end
        12'h028: begin
          item_a_o <= mk(OP_TABLE_CALL_PSEUDO, 2'h2, 1'b1, 13'h0abc);
        end
        12'h02a: begin
          item_a_o <= mk(OP_LD_A_IND, 2'h1, 1'b0, 13'h0000);
          item_b_o <= mk(OP_DECREMENT_SKIP_OP_R, 2'h1, 1'b1, 13'h0000);
          two_o <= 1'b1;
        end
        12'h02c: begin
          item_a_o <= mk(OP_ST_A_IND, 2'h1, 1'b1, 13'h0000);
          two_o <= 1'b1;
        end
        12'h02e: item_a_o <= mk(OP_LD_XACC_IMM, 2'h2, 1'b1, 13'h0000);
        default: item_a_o <= mk(OP_OTHER, 2'h2, 1'b1, 13'h0000);
      endcase
    end
  end
endmodule : sarseq_mem_model

`default_nettype wire

/* tb/tb.sv */
// Self-checking bench of the skip and table reference sequencer
`timescale 1ns/10ps
`default_nettype none

module tb;
  import sarseq_pkg::*;

  // ==========================================
  // Signals
  // Row code: nop, carry write, pc_inc[2], extra[2], skip, skip checked
  typedef struct packed {
    sarseq_op_t  op;
    logic [1:0]  len;
    sarseq_res_t r;
    logic [7:0]  e;
  } sarseq_row_t;

  logic         ref_clk_i = 1'b0;
  logic         rst_n_i = 1'b0;
  logic         ce_i = 1'b1;
  logic         ins_valid_i = 1'b0;
  sarseq_ins_t  ins_i = '0;
  sarseq_res_t  res_i = '0;
  sarseq_ctx_t  ctx_i = '0;
  sarseq_ctl_t  ctl_o, ctl, ctl_a;
  sarseq_treq_t treq_o, treq;
  sarseq_bita_t bita_o, bita;
  logic         skip_o;
  sarseq_ins_t  item_a, item_b;
  logic         two;
  sarseq_row_t  rows [19];
  sarseq_ins_t  i;
  int           err_count = 0;
  int           checks_done = 0;
  int           cyc = 0;

  sarseq_core sarseq_core_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .ce_i(ce_i), .ins_valid_i(ins_valid_i), .ins_i(ins_i), .res_i(res_i),
    .ctx_i(ctx_i), .ctl_o(ctl_o), .treq_o(treq_o), .bita_o(bita_o),
    .skip_o(skip_o));
  sarseq_mem_model sarseq_mem_model_i (.ref_clk_i(ref_clk_i),
    .treq_i(treq_o), .item_a_o(item_a), .item_b_o(item_b), .two_o(two));

  always #5 ref_clk_i = ~ref_clk_i;

  // Whole run needs about 110 cycles; ceiling leaves wide margin
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      give_verdict();
    end
  end

  // ==========================================
  // Tasks
  function automatic sarseq_ins_t mk(sarseq_op_t op, logic [1:0] len);
    mk = '0;
    mk.op = op;
    mk.len = len;
    mk.msb = 1'b1;
  endfunction : mk

  task automatic chk(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask : chk

  // One instruction in flight; answer sampled the cycle after taking
  task automatic issue(input sarseq_ins_t n, input sarseq_res_t r);
    @(posedge ref_clk_i);
    #1;
    ins_valid_i = 1'b1;
    ins_i = n;
    res_i = r;
    @(posedge ref_clk_i);
    #1;
    ins_valid_i = 1'b0;
    ctl = ctl_o;
    treq = treq_o;
    bita = bita_o;
    chk(ctl.valid, 1'b1, "valid");
  endtask : issue

  task automatic ref_entry(input logic [5:0] idx, input sarseq_res_t r2,
                           input logic only_a);
    sarseq_ins_t n;
    n = mk(OP_REF, 2'h1);
    n.tidx = idx;
    issue(n, '0);
    chk(treq.valid, 1'b1, "treq");
    chk(treq.addr, {5'h00, idx, 1'b0}, "taddr");
    chk(ctl.pc_inc, 2'h0, "hold");
    // Model answers on the edge after the request; take the item after it
    @(posedge ref_clk_i);
    #1;
    issue(item_a, '0);
    ctl_a = ctl;
    if (two && !only_a) issue(item_b, r2);
  endtask : ref_entry

  task automatic bit_case(input sarseq_bm_t m, input logic hi,
    input logic [3:0] da, input sarseq_ctx_t c, input logic [11:0] a,
    input logic [1:0] b);
    sarseq_ins_t n;
    n = mk(OP_BIT, 2'h2);
    n.bmode = m;
    n.bhigh = hi;
    n.da = da;
    n.bitn = 2'h2;
    ctx_i = c;
    issue(n, '0);
    chk(bita.valid, 1'b1, "bvalid");
    chk(bita.addr, a, "baddr");
    chk(bita.bitn, b, "bitn");
  endtask : bit_case

  task give_verdict;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  // ==========================================
  // Sequence
  initial begin
    rows[0] = '{OP_STEP_SKIP, 2'h1, 3'h4, 8'h13};
    rows[1] = '{OP_OTHER, 2'h3, 3'h0, 8'hb9};
    rows[2] = '{OP_TEST_SKIP, 2'h2, 3'h1, 8'h23};
    rows[3] = '{OP_OTHER, 2'h2, 3'h0, 8'ha5};
    rows[4] = '{OP_CARRY, 2'h1, 3'h5, 8'h51};
    rows[5] = '{OP_LD_A_IMM, 2'h1, 3'h0, 8'h11};
    rows[6] = '{OP_LD_XACC_IMM, 2'h2, 3'h0, 8'ha1};
    rows[7] = '{OP_LD_A_IMM, 2'h1, 3'h0, 8'h91};
    rows[8] = '{OP_LD_PTR_IMM, 2'h2, 3'h0, 8'h21};
    rows[9] = '{OP_LD_PTR_IMM, 2'h2, 3'h0, 8'ha1};
    rows[10] = '{OP_ADD_CARRY_IND, 2'h1, 3'h4, 8'h50};
    rows[11] = '{OP_ADD_AND_SKIP, 2'h1, 3'h0, 8'h95};
    rows[12] = '{OP_SUB_BORROW_IND, 2'h1, 3'h2, 8'h50};
    rows[13] = '{OP_ADD_AND_SKIP, 2'h1, 3'h4, 8'h11};
    rows[14] = '{OP_OTHER, 2'h1, 3'h0, 8'h11};
    rows[15] = '{OP_SUB_BORROW_IND, 2'h1, 3'h0, 8'h50};
    rows[16] = '{OP_ADD_AND_SKIP, 2'h1, 3'h0, 8'h95};
    rows[17] = '{OP_ADD_AND_SKIP, 2'h1, 3'h4, 8'h13};
    rows[18] = '{OP_OTHER, 2'h1, 3'h0, 8'h95};
    repeat (3) @(posedge ref_clk_i);
    #1;
    rst_n_i = 1'b1;
    chk(ctl_o, '0, "rst ctl");
    chk(skip_o, 1'b0, "rst skip");
    foreach (rows[k]) begin
      issue(mk(rows[k].op, rows[k].len), rows[k].r);
      chk(ctl.nop, rows[k].e[7], "nop");
      chk(ctl.exec, !rows[k].e[7], "exec");
      chk(ctl.carry_we, rows[k].e[6], "cw");
      chk(ctl.pc_inc, rows[k].e[5:4], "pc");
      chk(ctl.extra, rows[k].e[3:2], "extra");
      if (rows[k].e[0]) begin
        chk(skip_o, rows[k].e[1], "skip");
      end
    end
    issue(mk(OP_LD_XACC_IMM, 2'h2), '0);
    ref_entry(6'h17, '0, 1'b0);
    chk(ctl_a.exec, 1'b1, "cancel");
    chk(ctl_a.tbl, 1'b1, "tbl");
    chk(ctl.pc_inc, 2'h1, "resume");
    issue(mk(OP_LD_A_IMM, 2'h1), '0);
    chk(ctl.nop, 1'b1, "after");
    ref_entry(6'h10, 3'h4, 1'b0);
    chk(ctl_a.exec, 1'b1, "pair1");
    chk(ctl.exec & ctl.tbl, 1'b1, "pair2");
    chk(ctl.pc_inc, 2'h1, "resume2");
    chk(skip_o, 1'b1, "tskip");
    issue(mk(OP_OTHER, 2'h1), '0);
    chk(ctl.nop, 1'b1, "next");
    chk(ctl.extra, 2'h1, "cost");
    issue(mk(OP_STEP_SKIP, 2'h1), 3'h4);
    i = mk(OP_REF, 2'h1);
    i.tidx = 6'h10;
    issue(i, '0);
    chk(ctl.nop, 1'b1, "refskip");
    chk(ctl.extra, 2'h1, "refcost");
    chk(treq.valid, 1'b0, "nofetch");
    for (int j = 6'h13; j <= 6'h14; j++) begin
      ref_entry(6'(j), '0, 1'b0);
      chk(ctl.jump, j == 6'h13, "jump");
      chk(ctl.call, j == 6'h14, "call");
      chk(ctl.tgt, (j == 6'h13) ? 13'h1234 : 13'h0abc, "tgt");
      chk(ctl.pc_inc, 2'h0, "branch");
    end
    for (int j = 0; j < 3; j++) begin
      ref_entry(6'h12 + 6'(j) + ((j > 0) ? 6'h02 : 6'h00), '0, j == 1);
      chk({ctl.err, ctl.nop, ctl.exec}, 3'h6, "refuse");
      chk(ctl.pc_inc, 2'h1, "rend");
    end
    i.tidx = 6'h08;
    issue(i, '0);
    chk(ctl.err, 1'b1, "range");
    bit_case(BM_ABS, 1'b0, 4'h5, '0, 12'hfb5, 2'h2);
    bit_case(BM_ABS, 1'b1, 4'h5, '0, 12'hff5, 2'h2);
    bit_case(BM_PTR_LOW, 1'b0, 4'h8, 13'h0e00, 12'hfc9, 2'h3);
    bit_case(BM_PTR_HIGH, 1'b0, 4'h3, 13'h0120, 12'hf93, 2'h2);
    bit_case(BM_PTR_HIGH, 1'b0, 4'h4, 13'h0032, 12'h214, 2'h2);
    // Enable low must freeze a pending skip; a reset then drops it
    issue(mk(OP_STEP_SKIP, 2'h1), 3'h4);
    @(posedge ref_clk_i);
    #1;
    ce_i = 1'b0;
    ins_valid_i = 1'b1;
    ins_i = mk(OP_OTHER, 2'h1);
    @(posedge ref_clk_i);
    #1;
    ins_valid_i = 1'b0;
    chk(ctl_o.valid, 1'b0, "frozen");
    chk(skip_o, 1'b1, "held");
    ce_i = 1'b1;
    rst_n_i = 1'b0;
    @(posedge ref_clk_i);
    #1;
    rst_n_i = 1'b1;
    chk(ctl_o, '0, "rst2 ctl");
    chk(skip_o, 1'b0, "rst2 skip");
    issue(mk(OP_OTHER, 2'h1), '0);
    chk(ctl.exec, 1'b1, "after rst");
    give_verdict();
  end
endmodule : tb

`default_nettype wire
